// [verilog/spl_pkg.sv]
// shared constants for the serial port select, loopback and enable block
package spl_pkg;
  localparam int CHANNELS = 4;
  localparam int DRIVERS = 8;
  localparam int AV_ADDR_W = 4;
  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int CTRL_MUTE_BIT = 0;
  localparam logic CTRL_RESET = 1'h0;
  localparam logic [7:0] DRV_EN_RESET = 8'h00;
  // status fields
  localparam int ST_EN_LSB = 0;
  localparam int ST_SEL_LSB = 8;
  localparam int ST_LOOP_BIT = 12;
  localparam int ST_LEVEL_LSB = 13;
  // ---------------------------------------------------------------------
  // three-level threshold codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;
  // driver index -> enable bus bit; drivers 0..3 primary a..d, 4..7 secondary
  localparam logic [2:0] DRV_MAP [DRIVERS] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7
  };
endpackage

// [verilog/spl_sync.sv]
// two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/10ps
module spl_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } spl_sync_t;

  spl_sync_t s_q;
  spl_sync_t s_d;

  always_comb begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  // no reset: only the second stage is ever read
  always_ff @(posedge clk_in) begin
    s_q <= s_d;
  end

  assign sync_out = s_q.sync;
endmodule // spl_sync

// [verilog/spl_port_ctrl.sv]
// serial port input select, all-port loopback and driver enable latch
`timescale 1ns/10ps
module spl_port_ctrl
  import spl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [CHANNELS-1:0] primary_serial_in,
  input wire logic [CHANNELS-1:0] secondary_serial_in,
  input wire logic [CHANNELS-1:0] rx_input_select_in,
  input wire logic [CHANNELS-1:0] tx_serial_in,
  input wire logic all_port_loopback_en_in,
  input wire logic drv_enable_latch_open_in,
  input wire logic [DRIVERS-1:0] shared_enable_bus_in,
  input wire logic device_reset_n_in,
  input wire logic [1:0] amplitude_threshold_sel_in,
  input wire logic [AV_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [CHANNELS-1:0] cdr_serial_out,
  output logic [DRIVERS-1:0] serial_out_driver_out,
  output logic [DRIVERS-1:0] drv_enable_out,
  output logic [1:0] threshold_level_out
);
  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  localparam int SW = 3 * CHANNELS + DRIVERS + 5;
  logic [SW-1:0] pins_s;
  logic [CHANNELS-1:0] prim_s;
  logic [CHANNELS-1:0] sec_s;
  logic [CHANNELS-1:0] sel_s;
  logic loop_s;
  logic open_s;
  logic [DRIVERS-1:0] bus_s;
  logic dev_rst_n_s;
  logic [1:0] thr_s;

  // bits of one shared synchroniser may still land a cycle apart, so
  // open and bus should not be changed in the same cycle
  spl_sync #(.W(SW)) u_sync (
    .clk_in(clk_in),
    .async_in({primary_serial_in, secondary_serial_in, rx_input_select_in,
               all_port_loopback_en_in, drv_enable_latch_open_in,
               shared_enable_bus_in, device_reset_n_in,
               amplitude_threshold_sel_in}),
    .sync_out(pins_s)
  );

  assign {prim_s, sec_s, sel_s, loop_s, open_s, bus_s, dev_rst_n_s, thr_s}
    = pins_s;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [DRIVERS-1:0] map_bus(
    input logic [DRIVERS-1:0] bus
  );
    logic [DRIVERS-1:0] r;
    r = '0;
    for (int i = 0; i < DRIVERS; i++) begin
      r[i] = bus[DRV_MAP[i]];
    end
    return r;
  endfunction

  // open pin code 11 is taken as mid, the safe middle trip point
  function automatic logic [1:0] decode_level(input logic [1:0] code);
    logic [1:0] r;
    r = LEVEL_MID;
    if (code == LEVEL_LOW || code == LEVEL_HIGH) begin
      r = code;
    end
    return r;
  endfunction

  // unmapped addresses read as zero
  function automatic logic [31:0] read_word(
    input logic [AV_ADDR_W-1:0] addr,
    input logic mute,
    input logic [31:0] status
  );
    logic [31:0] r;
    r = '0;
    unique case (addr)
      CTRL_OFFSET: r[CTRL_MUTE_BIT] = mute;
      STATUS_OFFSET: r = status;
      default: r = '0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [DRIVERS-1:0] en;
    logic mute;
    logic wait_n;
    logic [31:0] rdata;
    logic [CHANNELS-1:0] cdr;
    logic [DRIVERS-1:0] drv;
    logic [1:0] level;
    logic [DRIVERS-1:0] oe;
  } spl_state_t;

  spl_state_t s_q;
  spl_state_t s_d;
  logic [DRIVERS-1:0] en_eff;
  logic [31:0] status_w;

  always_comb begin
    s_d = s_q;
    en_eff = '0;
    status_w = '0;

    // -------------------------------------------------------------------
    // driver enable latch
    // -------------------------------------------------------------------
    // a clocked stage stands in for the transparent latch: the enables
    // trail the bus by the synchroniser delay but cannot glitch
    if (!dev_rst_n_s) begin
      s_d.en = DRV_EN_RESET;
    end else if (open_s) begin
      s_d.en = map_bus(bus_s);
    end // otherwise held

    // mute gates the drivers but keeps the latch contents
    en_eff = s_d.en & {DRIVERS{~s_q.mute}};
    s_d.oe = en_eff;

    // -------------------------------------------------------------------
    // receive path select and loopback
    // -------------------------------------------------------------------
    for (int c = 0; c < CHANNELS; c++) begin
      if (loop_s) begin
        s_d.cdr[c] = tx_serial_in[c];
      end else begin
        s_d.cdr[c] = sel_s[c] ? prim_s[c] : sec_s[c];
      end
    end

    // -------------------------------------------------------------------
    // serial drivers
    // -------------------------------------------------------------------
    for (int i = 0; i < DRIVERS; i++) begin
      // a powered-down driver idles low
      if (!en_eff[i]) begin
        s_d.drv[i] = 1'b0;
      end else if (loop_s) begin
        s_d.drv[i] = 1'b1;
      end else begin
        s_d.drv[i] = tx_serial_in[i % CHANNELS];
      end
    end

    // -------------------------------------------------------------------
    // signal detect threshold
    // -------------------------------------------------------------------
    s_d.level = decode_level(thr_s);

    // -------------------------------------------------------------------
    // avalon slave
    // -------------------------------------------------------------------
    // status shows synced select and loop pins, read three edges late; enable and level fields come from state and read one edge later
    status_w[ST_EN_LSB +: DRIVERS] = s_q.en;
    status_w[ST_SEL_LSB +: CHANNELS] = sel_s;
    status_w[ST_LOOP_BIT] = loop_s;
    status_w[ST_LEVEL_LSB +: 2] = s_q.level;
    s_d.wait_n = 1'b0;
    if ((avs_read_in || avs_write_in) && !s_q.wait_n) begin
      s_d.wait_n = 1'b1;
      if (avs_read_in) begin
        s_d.rdata = read_word(avs_address_in, s_q.mute, status_w);
      end
    end
    // a write lands only at the completing edge, when waitrequest is low;
    // read data was captured one cycle earlier and stands meanwhile
    if (avs_write_in && s_q.wait_n && avs_address_in == CTRL_OFFSET &&
        avs_byteenable_in[0]) begin
      s_d.mute = avs_writedata_in[CTRL_MUTE_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.en <= DRV_EN_RESET;
      s_q.mute <= CTRL_RESET;
      s_q.level <= LEVEL_MID;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------
  // outputs, each straight from the state register
  // ---------------------------------------------------------------------
  assign avs_readdata_out = s_q.rdata;
  assign avs_waitrequest_out = ~s_q.wait_n;
  assign cdr_serial_out = s_q.cdr;
  assign serial_out_driver_out = s_q.drv;
  assign drv_enable_out = s_q.oe;
  assign threshold_level_out = s_q.level;
endmodule // spl_port_ctrl

// [bench/spl_properties.sv]
// assertions for the port select, loopback and driver enable block
`timescale 1ns/10ps
module spl_props
  import spl_pkg::*;
(
  input logic clk_in, rst_in, all_port_loopback_en_in, device_reset_n_in,
  input logic drv_enable_latch_open_in, avs_read_in, avs_write_in,
  input logic avs_waitrequest_out,
  input logic [3:0] primary_serial_in, secondary_serial_in, tx_serial_in,
  input logic [3:0] rx_input_select_in, cdr_serial_out,
  input logic [7:0] shared_enable_bus_in, drv_enable_out,
  input logic [7:0] serial_out_driver_out,
  input logic [1:0] amplitude_threshold_sel_in, threshold_level_out
);
  logic [2:0] up_q;
  logic ok;
  // pins need three edges to land, so hold off after each reset
  always_ff @(posedge clk_in)
    up_q <= rst_in ? 3'h0 : up_q + 3'(up_q != 3'h4);
  assign ok = up_q == 3'h4;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_take;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  property p_ack;
    s_take |=> !avs_waitrequest_out;
  endproperty
  a_ack: assert property (p_ack) else $error("bus not answered");
  property p_mux;
    ok && !$past(all_port_loopback_en_in, 3) |-> cdr_serial_out ==
      ($past(rx_input_select_in, 3) & $past(primary_serial_in, 3) |
      ~$past(rx_input_select_in, 3) & $past(secondary_serial_in, 3));
  endproperty
  a_mux: assert property (p_mux) else $error("input select");
  property p_loop;
    ok && $past(all_port_loopback_en_in, 3) |->
      cdr_serial_out == $past(tx_serial_in);
  endproperty
  a_loop: assert property (p_loop) else $error("loop route");
  property p_drv;
    ok && !$past(all_port_loopback_en_in, 3) && $stable(drv_enable_out) |->
      serial_out_driver_out == (drv_enable_out & {2{$past(tx_serial_in)}});
  endproperty
  a_drv: assert property (p_drv) else $error("driver data");
  property p_lpdrv;
    ok && $past(all_port_loopback_en_in, 3) |->
      serial_out_driver_out == drv_enable_out;
  endproperty
  a_lpdrv: assert property (p_lpdrv) else $error("loop drivers");
  property p_open;
    ok && $past(drv_enable_latch_open_in, 3) && $past(device_reset_n_in, 3)
      |-> (drv_enable_out & ~$past(shared_enable_bus_in, 3)) == 8'h00;
  endproperty
  a_open: assert property (p_open) else $error("open latch");
  // mute toggles to or from zero, so only nonzero pairs are compared
  property p_hold;
    ok && !$past(drv_enable_latch_open_in, 3) && $past(device_reset_n_in, 3)
      && drv_enable_out != 8'h00 && $past(drv_enable_out) != 8'h00
      |-> $stable(drv_enable_out);
  endproperty
  a_hold: assert property (p_hold) else $error("latch hold");
  property p_rst;
    ok && !$past(device_reset_n_in, 3) |-> drv_enable_out == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("latch clear");
  property p_lvl;
    ok |-> threshold_level_out == ($past(amplitude_threshold_sel_in, 3)
      == LEVEL_HIGH ? LEVEL_HIGH : $past(amplitude_threshold_sel_in, 3)
      == LEVEL_LOW ? LEVEL_LOW : LEVEL_MID);
  endproperty
  a_lvl: assert property (p_lvl) else $error("threshold");
endmodule // spl_props
bind spl_port_ctrl spl_props props_u (.*);

// [bench/spl_line_model.sv]
// far-side line model: two serial sources that never idle
`timescale 1ns/10ps
module spl_line_model (
  input wire logic clk_in,
  output logic [3:0] primary_out,
  output logic [3:0] secondary_out
);
  logic [3:0] cnt_q = 4'h0;
  // changing every cycle makes a stale or wrong pick show at once
  always @(posedge clk_in) cnt_q <= cnt_q + 4'h3;
  assign primary_out = cnt_q;
  assign secondary_out = ~{cnt_q[0], cnt_q[3:1]};
endmodule // spl_line_model

// [bench/testbench.sv]
// self-checking bench for the port select and driver enable block
`timescale 1ns/10ps
module testbench
  import spl_pkg::*;
;
  logic clk_in, rst_in, all_port_loopback_en_in, drv_enable_latch_open_in;
  logic device_reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [3:0] primary_serial_in, secondary_serial_in, rx_input_select_in;
  logic [3:0] tx_serial_in, avs_address_in, avs_byteenable_in, cdr_serial_out;
  logic [7:0] shared_enable_bus_in, serial_out_driver_out, drv_enable_out;
  logic [1:0] amplitude_threshold_sel_in, threshold_level_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  int mismatches, comparisons;
  spl_port_ctrl dut_u (.*);
  spl_line_model line_u (.clk_in, .primary_out(primary_serial_in),
    .secondary_out(secondary_serial_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n == 20) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_select();
    logic [3:0] p, s;
    tick(1);
    p = primary_serial_in;
    s = secondary_serial_in;
    tick(3);
    p = p & rx_input_select_in | s & ~rx_input_select_in;
    chk(cdr_serial_out, p);
  endtask
  task automatic t_latch();
    @(posedge clk_in) drv_enable_latch_open_in <= 1'b1;
    shared_enable_bus_in <= 8'h3c;
    tick(4);
    chk(drv_enable_out, 8'h3c);
    chk(serial_out_driver_out, 8'h18);
    @(posedge clk_in) drv_enable_latch_open_in <= 1'b0;
    shared_enable_bus_in <= 8'hc3;
    tick(4);
    chk(drv_enable_out, 8'h3c);
  endtask
  task automatic t_loop();
    @(posedge clk_in) all_port_loopback_en_in <= 1'b1;
    tick(4);
    chk(cdr_serial_out, tx_serial_in);
    chk(serial_out_driver_out, 8'h3c);
    @(posedge clk_in) tx_serial_in <= 4'h6;
    tick(1);
    chk(cdr_serial_out, 4'h6);
    @(posedge clk_in) all_port_loopback_en_in <= 1'b0;
  endtask
  task automatic t_bus();
    av(1'b1, CTRL_OFFSET, 32'h1);
    tick(4);
    chk(drv_enable_out, 8'h00);
    av(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, 32'h1);
    av(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd[11:0], 12'h53c);
    av(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    av(1'b1, CTRL_OFFSET, 32'h0);
    tick(4);
    chk(drv_enable_out, 8'h3c);
  endtask
  task automatic t_level();
    logic [1:0] e [4] = '{LEVEL_LOW, LEVEL_MID, LEVEL_HIGH, LEVEL_MID};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in) amplitude_threshold_sel_in <= 2'(i);
      tick(4);
      chk(threshold_level_out, e[i]);
    end
  endtask
  task automatic t_devrst();
    @(posedge clk_in) device_reset_n_in <= 1'b0;
    drv_enable_latch_open_in <= 1'b1;
    shared_enable_bus_in <= 8'hff;
    tick(4);
    chk(drv_enable_out, 8'h00);
    @(posedge clk_in) device_reset_n_in <= 1'b1;
    drv_enable_latch_open_in <= 1'b0;
    tick(4);
    chk(drv_enable_out, 8'h00);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    {rst_in, device_reset_n_in, avs_read_in, avs_write_in} = 4'hc;
    {all_port_loopback_en_in, drv_enable_latch_open_in} = 2'h0;
    {rx_input_select_in, tx_serial_in, avs_address_in} = 12'h590;
    {avs_byteenable_in, shared_enable_bus_in} = 12'hf00;
    {amplitude_threshold_sel_in, avs_writedata_in} = 34'h0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    t_select();
    t_latch();
    t_loop();
    t_bus();
    t_level();
    t_devrst();
    summarize();
  end
endmodule // testbench
